// ### rtl/sac_top.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top #(
  parameter int CAL_PERIODS = `SAC_CAL_PERIODS
) (
  // System clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // Serial link clock
  input  wire logic                     sclk,
  // Control pins from the host
  input  wire logic                     sample_start_n_clk,
  input  wire logic                     sample_start_n,
  input  wire logic                     cs_n,
  input  wire logic                     reset_cal_n,
  // Three-level range pin, seen as two level detectors
  input  wire logic                     range_shutdown_select_low,
  input  wire logic                     range_shutdown_select_high,
  // Comparator decision from the analog core
  input  wire logic                     comp_high,
  // Framing and serial data to the host
  output logic                          eoc,
  output logic                          dout,
  output logic                          dout_oe,
  // Analog core control
  output logic [`SAC_RES_BITS-1:0]      dac_code,
  output logic                          track_enable,
  output logic                          range_bipolar,
  output logic                          shutdown,
  output logic                          calibrating
);

  localparam logic [`SAC_CAL_W-1:0] CAL_LAST = `SAC_CAL_W'(CAL_PERIODS - 1);

  // Settled copies of the pins
  wire logic               sample_start_n_clk_s;
  wire logic               start_n_s;
  wire logic               cs_n_s;
  wire logic               reset_cal_s;
  wire logic               range_low_s;
  wire logic               range_high_s;
  sac_pkg::sac_idx_t       idx_gray_link;
  sac_pkg::sac_idx_t       idx_gray_s;

  // Control state
  sac_pkg::sac_state_t     state_reg;
  sac_pkg::sac_state_t     state_next;
  logic [`SAC_CAL_W-1:0]   cal_cnt_reg;
  logic [`SAC_CAL_W-1:0]   cal_cnt_next;
  logic [1:0]              acq_cnt_reg;
  logic [1:0]              acq_cnt_next;
  logic                    pend_reg;
  logic                    pend_next;
  logic [3:0]              bit_idx_reg;
  logic [3:0]              bit_idx_next;
  logic [`SAC_RES_BITS-1:0] sar_reg;
  logic [`SAC_RES_BITS-1:0] sar_next;
  logic [`SAC_RES_BITS-1:0] result_reg;
  logic [`SAC_RES_BITS-1:0] result_next;
  logic                    sample_start_n_bit_reg;
  logic                    sample_start_n_bit_next;
  logic                    track_reg;
  logic                    track_next;
  logic                    clk_prev_reg;
  logic                    start_prev_reg;
  logic                    reset_prev_reg;

  // Events and decoded levels
  wire logic               fall_evt;
  wire logic               start_evt;
  wire logic               reset_rise;
  wire logic               busy;
  wire logic               sample_start_n_active;
  wire logic               decided_bit;
  wire logic [`SAC_RES_BITS-1:0] sar_decided;
  wire logic [`SAC_IDX_W-1:0]    idx_bin;
  wire logic               ser_bit;
  wire logic               dout_next;
  wire logic               shutdown_next;
  wire logic               bipolar_next;

  // Fix one bit and raise the trial bit just below it
  function automatic logic [`SAC_RES_BITS-1:0] sar_step(
    input logic [`SAC_RES_BITS-1:0] word,
    input logic [3:0]               idx,
    input logic                     bit_val
  );
    logic [`SAC_RES_BITS-1:0] w;
    w      = word;
    w[idx] = bit_val;
    if (idx != `SAC_LSB) begin
      w[idx - `SAC_BIT_ONE] = 1'b1;
    end
    sar_step = w;
  endfunction

  // Pin synchronisers
  sac_sync3 #(.W(1), .INIT(1'b0)) u_sync_clk (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (sample_start_n_clk),
    .q     (sample_start_n_clk_s)
  );

  sac_sync3 #(.W(1), .INIT(1'b1)) u_sync_start (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (sample_start_n),
    .q     (start_n_s)
  );

  sac_sync3 #(.W(1), .INIT(1'b1)) u_sync_cs (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (cs_n),
    .q     (cs_n_s)
  );

  // Starts low so that a pin already high at power-up still calibrates
  sac_sync3 #(.W(1), .INIT(1'b0)) u_sync_reset (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (reset_cal_n),
    .q     (reset_cal_s)
  );

  sac_sync3 #(.W(2), .INIT(2'h0)) u_sync_range (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   ({range_shutdown_select_low, range_shutdown_select_high}),
    .q     ({range_low_s, range_high_s})
  );

  // Serial position counter on the link clock, crossing back as gray code
  sac_serial_idx u_serial_idx (
    .sclk     (sclk),
    .rst_n    (rst_n),
    .cs_n     (cs_n),
    .idx_gray (idx_gray_link)
  );

  sac_sync3 #(.W(`SAC_IDX_W), .INIT(`SAC_IDX_ZERO)) u_sync_idx (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (idx_gray_link),
    .q     (idx_gray_s)
  );

  // Edge detection on settled pins
  assign fall_evt    = clk_prev_reg & ~sample_start_n_clk_s;
  assign start_evt   = start_prev_reg & ~start_n_s;
  assign reset_rise  = ~reset_prev_reg & reset_cal_s;
  assign busy        = (state_reg == sac_pkg::ST_CAL) | (state_reg == sac_pkg::ST_SAMPLE_START_N);
  assign sample_start_n_active = eoc & (state_reg != sac_pkg::ST_CAL);

  // Comparator low means the input lies above the trial level
  assign decided_bit = ~comp_high;
  assign sar_decided = sar_step(sar_reg, bit_idx_reg, decided_bit);

  // Low wins if both detectors fire, so a marginal pin errs toward shutdown
  assign shutdown_next = range_low_s;
  assign bipolar_next  = ~range_low_s & ~range_high_s;

  // Serial output picks the result bit at the host's position, MSB at position zero; while eoc is high outside calibration it gives the bit just decided
  assign idx_bin   = sac_pkg::sac_gray2bin(idx_gray_s);
  assign ser_bit   = (idx_bin < `SAC_IDX_END) ? result_reg[`SAC_MSB - idx_bin[3:0]] : 1'b0;
  assign dout_next = sample_start_n_active ? sample_start_n_bit_reg : ser_bit;

  always_comb begin
    state_next    = state_reg;
    cal_cnt_next  = cal_cnt_reg;
    acq_cnt_next  = acq_cnt_reg;
    pend_next     = pend_reg;
    bit_idx_next  = bit_idx_reg;
    sar_next      = sar_reg;
    result_next   = result_reg;
    sample_start_n_bit_next = sample_start_n_bit_reg;
    track_next    = track_reg;
    // Starts count only while waiting; during conversion they fall away
    if (start_evt && (state_reg == sac_pkg::ST_ACQ)) begin
      pend_next = 1'b1;
    end
    if (shutdown_next) begin
      pend_next = 1'b0;
    end
    if (!reset_cal_s) begin
      state_next = sac_pkg::ST_HALT;
      pend_next  = 1'b0;
      track_next = 1'b1;
    end else begin
      case (state_reg)
        sac_pkg::ST_HALT: begin
          if (reset_rise) begin
            state_next    = sac_pkg::ST_CAL;
            cal_cnt_next  = `SAC_CAL_ZERO;
            acq_cnt_next  = `SAC_ACQ_ZERO;
            pend_next     = 1'b0;
            bit_idx_next  = `SAC_MSB;
            sar_next      = `SAC_WORD_ZERO;
            result_next   = `SAC_WORD_ZERO;
            sample_start_n_bit_next = 1'b0;
            track_next    = 1'b1;
          end
        end
        sac_pkg::ST_CAL: begin
          if (fall_evt) begin
            if (cal_cnt_reg == CAL_LAST) begin
              state_next   = sac_pkg::ST_ACQ;
              acq_cnt_next = `SAC_ACQ_ZERO;
            end else begin
              cal_cnt_next = cal_cnt_reg + `SAC_CAL_ONE;
            end
          end
        end
        sac_pkg::ST_ACQ: begin
          if (fall_evt) begin
            // Ready after three edges, so the earliest start lands on the fourth
            if (pend_reg && (acq_cnt_reg == `SAC_ACQ_READY) && !shutdown_next) begin
              state_next   = sac_pkg::ST_SAMPLE_START_N;
              bit_idx_next = `SAC_MSB;
              sar_next     = `SAC_MSB_TRIAL;
              pend_next    = 1'b0;
              track_next   = 1'b0;
            end else if (acq_cnt_reg != `SAC_ACQ_READY) begin
              acq_cnt_next = acq_cnt_reg + `SAC_ACQ_ONE;
            end
          end
        end
        sac_pkg::ST_SAMPLE_START_N: begin
          if (fall_evt) begin
            sar_next      = sar_decided;
            sample_start_n_bit_next = decided_bit;
            if (bit_idx_reg == `SAC_LSB) begin
              result_next  = sar_decided;
              state_next   = sac_pkg::ST_ACQ;
              acq_cnt_next = `SAC_ACQ_ZERO;
              track_next   = 1'b1;
            end else begin
              bit_idx_next = bit_idx_reg - `SAC_BIT_ONE;
            end
          end
        end
        default: begin
          state_next = sac_pkg::ST_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg   <= 1'b0;
      start_prev_reg <= 1'b1;
      reset_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg   <= sample_start_n_clk_s;
      start_prev_reg <= start_n_s;
      reset_prev_reg <= reset_cal_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= sac_pkg::ST_HALT;
      cal_cnt_reg  <= `SAC_CAL_ZERO;
      acq_cnt_reg  <= `SAC_ACQ_ZERO;
      pend_reg     <= 1'b0;
      bit_idx_reg  <= `SAC_MSB;
      sar_reg      <= `SAC_WORD_ZERO;
      result_reg   <= `SAC_WORD_ZERO;
      sample_start_n_bit_reg <= 1'b0;
      track_reg    <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cal_cnt_reg  <= cal_cnt_next;
      acq_cnt_reg  <= acq_cnt_next;
      pend_reg     <= pend_next;
      bit_idx_reg  <= bit_idx_next;
      sar_reg      <= sar_next;
      result_reg   <= result_next;
      sample_start_n_bit_reg <= sample_start_n_bit_next;
      track_reg    <= track_next;
    end
  end

  // Framing follows the busy state one conversion-clock edge late
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eoc <= 1'b0;
    end else if (!reset_cal_s) begin
      eoc <= 1'b0;
    end else if (fall_evt) begin
      eoc <= busy;
    end
  end

  // Output enable follows select; the pad resolves the level from it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout    <= dout_next;
      dout_oe <= ~cs_n_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_code      <= `SAC_WORD_ZERO;
      track_enable  <= 1'b1;
      range_bipolar <= 1'b0;
      shutdown      <= 1'b0;
      calibrating   <= 1'b0;
    end else begin
      dac_code      <= sar_next;
      track_enable  <= track_next;
      range_bipolar <= bipolar_next;
      shutdown      <= shutdown_next;
      calibrating   <= (state_next == sac_pkg::ST_CAL);
    end
  end

endmodule

// ### rtl/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_RES_BITS     16
`define SAC_MSB          4'hF
`define SAC_LSB          4'h0
`define SAC_MSB_TRIAL    16'h8000
`define SAC_WORD_ZERO    16'h0000
`define SAC_CAL_PERIODS  14000
`define SAC_CAL_W        14
`define SAC_CAL_ZERO     14'h0000
`define SAC_CAL_ONE      14'h0001
`define SAC_ACQ_ZERO     2'h0
`define SAC_ACQ_ONE      2'h1
`define SAC_ACQ_READY    2'h3
`define SAC_IDX_W        5
`define SAC_IDX_ZERO     5'h00
`define SAC_IDX_ONE      5'h01
`define SAC_IDX_END      5'h10
`define SAC_BIT_ONE      4'h1
`define SAC_SETTLE_US    50

`endif

// ### rtl/sac_pkg.sv
`include "sac_consts.svh"

package sac_pkg;

  typedef enum logic [1:0] {
    ST_HALT,
    ST_CAL,
    ST_ACQ,
    ST_SAMPLE_START_N
  } sac_state_t;

  typedef logic [`SAC_IDX_W-1:0] sac_idx_t;

  function automatic sac_idx_t sac_bin2gray(input sac_idx_t b);
    sac_bin2gray = b ^ (b >> 1);
  endfunction

  function automatic sac_idx_t sac_gray2bin(input sac_idx_t g);
    sac_idx_t b;
    b = g;
    for (int i = `SAC_IDX_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    sac_gray2bin = b;
  endfunction

endpackage

// ### rtl/sac_sync3.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_sync3 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and its settled copy
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;

  // A change is accepted only once the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg <= INIT;
      ff2_reg <= INIT;
      ff3_reg <= INIT;
      q       <= INIT;
    end else begin
      ff1_reg <= din;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      if (ff2_reg == ff3_reg) begin
        q <= ff3_reg;
      end
    end
  end

endmodule

// ### rtl/sac_serial_idx.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_serial_idx (
  // Serial link clock and reset
  input  wire logic             sclk,
  input  wire logic             rst_n,
  // Chip select, active low
  input  wire logic             cs_n,
  // Bit position as a gray code
  output sac_pkg::sac_idx_t     idx_gray
);

  sac_pkg::sac_idx_t cnt_reg;
  sac_pkg::sac_idx_t cnt_next;
  wire logic         sel_arst_n;

  // The frame's own select ends it, so a stopped serial clock never strands the count
  assign sel_arst_n = rst_n & ~cs_n;
  assign cnt_next   = (cnt_reg == `SAC_IDX_END) ? cnt_reg : cnt_reg + `SAC_IDX_ONE;

  // Host setup from select to first serial edge covers the reset release
  always_ff @(posedge sclk or negedge sel_arst_n) begin
    if (!sel_arst_n) begin
      cnt_reg  <= `SAC_IDX_ZERO;
      idx_gray <= `SAC_IDX_ZERO;
    end else begin
      cnt_reg  <= cnt_next;
      idx_gray <= sac_pkg::sac_bin2gray(cnt_next);
    end
  end

endmodule

// ### tb/sac_top_props.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top_props #(
  parameter int CAL_PERIODS = `SAC_CAL_PERIODS
) (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  // Host pins
  input wire logic                     cs_n,
  input wire logic                     reset_cal_n,
  input wire logic                     range_shutdown_select_low,
  input wire logic                     range_shutdown_select_high,
  // Block outputs
  input wire logic                     eoc,
  input wire logic                     dout_oe,
  input wire logic [`SAC_RES_BITS-1:0] dac_code,
  input wire logic                     track_enable,
  input wire logic                     range_bipolar,
  input wire logic                     shutdown,
  input wire logic                     calibrating
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Conversion clock runs at least ten system cycles a period
  int cal_len;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_len <= 0;
    end else if (!calibrating) begin
      cal_len <= 0;
    end else if (eoc) begin
      cal_len <= cal_len + 1;
    end
  end

  chk_oe_off: assert property (cs_n[*8] |-> !dout_oe)
    else $error("data output driven while deselected");
  chk_oe_on: assert property ((!cs_n)[*8] |-> dout_oe)
    else $error("data output idle while selected");
  chk_halt_quiet: assert property ((!reset_cal_n)[*8] |-> !eoc && !calibrating)
    else $error("activity while held in reset");
  chk_cal_start: assert property ($rose(reset_cal_n) |-> ##[1:12] calibrating)
    else $error("calibration did not start");
  chk_cal_eoc: assert property ($rose(calibrating) |-> !eoc ##[1:40] eoc)
    else $error("framing missing for calibration");
  chk_cal_len: assert property ($fell(calibrating) |-> cal_len >= (CAL_PERIODS - 1) * 10)
    else $error("calibration too short");
  chk_sample_start_n_trial: assert property ($fell(track_enable) && !calibrating
    |-> ##[0:1] dac_code == 16'h8000)
    else $error("first trial is not the top bit");
  chk_eoc_rise: assert property ($fell(track_enable) && !calibrating
    |-> !eoc ##[8:40] eoc)
    else $error("framing did not rise after start");
  chk_eoc_fall: assert property ($rose(track_enable) && eoc |-> ##[8:40] !eoc)
    else $error("framing did not fall after end");
  chk_shdn_block: assert property ($fell(track_enable) |-> !shutdown)
    else $error("conversion began in shutdown");
  chk_range_uni: assert property ((range_shutdown_select_high && !range_shutdown_select_low)[*8]
    |-> !shutdown && !range_bipolar)
    else $error("unipolar decode wrong");
  chk_range_float: assert property ((!range_shutdown_select_high && !range_shutdown_select_low)[*8]
    |-> range_bipolar && !shutdown)
    else $error("bipolar decode wrong");

  cover property ($rose(calibrating));
  cover property ($fell(track_enable) && !calibrating);
  cover property ($fell(cs_n) ##[1:8] dout_oe);
  cover property ($rose(shutdown));
endmodule

bind sac_top sac_top_props #(.CAL_PERIODS(CAL_PERIODS)) props (.clk_sys, .rst_n, .cs_n,
  .reset_cal_n, .range_shutdown_select_low, .range_shutdown_select_high, .eoc, .dout_oe,
  .dac_code, .track_enable, .range_bipolar, .shutdown, .calibrating);

// ### tb/sac_host_model.sv
`timescale 1ns/1ps

module sac_host_model (
  // Bench requests
  input  wire logic        rd_go,
  input  wire logic        sel_hold,
  input  wire logic [15:0] level,
  // Block pins
  input  wire logic        dout,
  input  wire logic        dout_oe,
  input  wire logic [15:0] dac_code,
  output logic             sclk,
  output logic             cs_n,
  output logic             comp_high,
  // Read result
  output logic [15:0]      rd_word,
  output logic             rd_done
);
  wire logic pin = dout_oe ? dout : 1'bz;
  logic      cs_rd;

  // Holding select low lets the bits be watched as they are decided
  assign cs_n = cs_rd & ~sel_hold;

  // Trial above the held input clears the bit
  assign comp_high = dac_code > level;

  initial begin
    sclk = 1'b0;
    cs_rd = 1'b1;
    rd_done = 1'b0;
    rd_word = 16'h0000;
    forever begin
      @(posedge rd_go);
      cs_rd = 1'b0;
      // Beyond the select setup; odd delay keeps edges off the system clock
      #81;
      for (int i = 15; i >= 0; i--) begin
        rd_word[i] = pin;
        sclk = 1'b1;
        #32;
        sclk = 1'b0;
        #32;
      end
      cs_rd = 1'b1;
      rd_done = 1'b1;
      @(negedge rd_go);
      rd_done = 1'b0;
    end
  end
endmodule

// ### tb/sac_top_tb.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top_tb;
  localparam int CAL = 8;
  localparam logic [15:0] LIVE = 16'h5A0F;
  logic        clk_sys, rst_n, sclk, sample_start_n, cs_n, reset_cal_n;
  logic        sample_start_n_clk = 1'b0;
  logic        range_shutdown_select_low, range_shutdown_select_high, comp_high;
  logic        eoc, dout, dout_oe, track_enable, range_bipolar, shutdown, calibrating;
  logic        rd_go, rd_done, sel_hold;
  logic [15:0] dac_code, level, rd_word;
  logic [2:0]  cdiv = 3'h0;
  logic [15:0] lv [4] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h8001};
  int          miscompares, samples_checked, n;

  sac_top #(.CAL_PERIODS(CAL)) dut (.clk_sys, .rst_n, .sclk, .sample_start_n_clk, .sample_start_n,
    .cs_n, .reset_cal_n, .range_shutdown_select_low, .range_shutdown_select_high, .comp_high,
    .eoc, .dout, .dout_oe, .dac_code, .track_enable, .range_bipolar, .shutdown, .calibrating);
  sac_host_model host (.rd_go, .sel_hold, .level, .dout, .dout_oe, .dac_code, .sclk, .cs_n,
    .comp_high,
    .rd_word, .rd_done);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Conversion clock at a sixteenth of the system clock, slow enough for its synchroniser
  always @(posedge clk_sys) begin
    cdiv <= cdiv + 3'h1;
    if (cdiv == 3'h7) begin
      sample_start_n_clk <= ~sample_start_n_clk;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask

  // Waits for eoc (0), calibrating (1) or rd_done (2); n holds the cycles spent
  task automatic wt(input int k, input logic v, input int lim);
    n = 0;
    while ((k == 0 ? eoc : (k == 1 ? calibrating : rd_done)) !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  task automatic pulse_start;
    sample_start_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    sample_start_n <= 1'b1;
  endtask

  task automatic read_back(input logic [15:0] exp);
    rd_go <= 1'b1;
    wt(2, 1'b1, 400);
    rd_go <= 1'b0;
    cmp(rd_word, exp);
    repeat (8) @(posedge clk_sys);
    cmp1(dout_oe, 1'b0);
  endtask

  task automatic t_cal;
    wt(1, 1'b1, 40);
    cmp1(calibrating, 1'b1);
    wt(0, 1'b1, 40);
    rng(n, 1, 39);
    wt(0, 1'b0, 400);
    rng(n, CAL * 16 - 8, CAL * 16 + 8);
    wt(1, 1'b0, 40);
    cmp1(calibrating, 1'b0);
    $display("calibration test done");
  endtask

  task automatic t_sample_start_n(input logic [15:0] lvl, input int lo, input int hi);
    level <= lvl;
    pulse_start();
    wt(0, 1'b1, 120);
    rng(n, lo, hi);
    wt(0, 1'b0, 400);
    rng(n, 248, 264);
    read_back(lvl);
    $display("conversion test done");
  endtask

  task automatic t_b2b;
    level <= LIVE;
    sel_hold <= 1'b1;
    pulse_start();
    wt(0, 1'b1, 120);
    pulse_start();
    // Each decided bit stands one conversion-clock period; look mid-period
    for (int b = 15; b >= 0; b--) begin
      repeat ((b == 15) ? 5 : 16) @(posedge clk_sys);
      cmp1(dout, LIVE[b]);
    end
    sel_hold <= 1'b0;
    wt(0, 1'b0, 400);
    wt(0, 1'b1, 150);
    rng(n, 150, 150);
    pulse_start();
    wt(0, 1'b1, 120);
    wt(0, 1'b0, 400);
    level <= 16'h3C96;
    pulse_start();
    wt(0, 1'b1, 120);
    rng(n, 52, 68);
    wt(0, 1'b0, 400);
    read_back(16'h3C96);
    $display("back-to-back test done");
  endtask

  task automatic t_range;
    for (int i = 0; i < 3; i++) begin
      range_shutdown_select_low <= (i == 0);
      range_shutdown_select_high <= (i == 2);
      repeat (12) @(posedge clk_sys);
      cmp1(shutdown, i == 0);
      cmp1(range_bipolar, i == 1);
      if (i == 0) begin
        pulse_start();
        wt(0, 1'b1, 300);
        rng(n, 300, 300);
      end
    end
    // Settling after leaving shutdown before relying on accuracy
    repeat (6250) @(posedge clk_sys);
    $display("range test done");
  endtask

  task automatic t_rcal;
    level <= 16'hC3A5;
    pulse_start();
    wt(0, 1'b1, 120);
    reset_cal_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    cmp1(eoc, 1'b0);
    pulse_start();
    wt(0, 1'b1, 200);
    rng(n, 200, 200);
    reset_cal_n <= 1'b1;
    t_cal();
    t_sample_start_n(16'hC3A5, 10, 72);
    $display("recalibration test done");
  endtask

  initial begin
    rst_n = 1'b0;
    sel_hold = 1'b0;
    sample_start_n = 1'b1;
    reset_cal_n = 1'b1;
    range_shutdown_select_low = 1'b0;
    range_shutdown_select_high = 1'b1;
    rd_go = 1'b0;
    level = 16'h0000;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    fork
      begin
        t_cal();
        repeat (80) @(posedge clk_sys);
        foreach (lv[i]) begin
          t_sample_start_n(lv[i], 10, 40);
        end
        t_b2b();
        t_range();
        t_rcal();
      end
      begin
        // Ceiling well above the roughly eleven thousand cycles the scenarios need
        repeat (40000) @(posedge clk_sys);
        miscompares++;
      end
    join_any
    final_report();
  end
endmodule
